/* dv/data_memory_bank_addressing_test.sv */
// Self-checking bench for the data memory bank addressing block
module data_memory_bank_addressing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, flag_set = 0, flag_clr = 0, bank_sel_wr = 0, ctx_enter = 0, ctx_return = 0;
    logic req_valid = 0, req_write = 0, bank_enable_flag, ram_sel, periph_sel, periph_rd, periph_wr, rd_valid;
    logic [3:0] bank_sel_wdata = 0, req_wdata = 0, periph_rdata, bank_select_reg, periph_wdata, rd_data;
    logic [7:0] direct_offset = 0, high_low_pair = 0, pointer_pair_two = 0, pointer_pair_three = 0;
    logic [7:0] stack_pointer = 0;
    logic [1:0] stack_bank_select = 0;
    logic [11:0] mem_addr;
    dmba_pkg::dmba_mode_t req_mode = dmba_pkg::DMBA_MODE_DIRECT;
    int error_cnt = 0, total_checks = 0;
    always #2.5 clock = ~clock;
    dmba_top dut (.clock(clock), .rst_n(rst_n), .flag_set(flag_set), .flag_clr(flag_clr), .bank_sel_wr(bank_sel_wr),
        .bank_sel_wdata(bank_sel_wdata), .ctx_enter(ctx_enter), .ctx_return(ctx_return), .req_valid(req_valid),
        .req_write(req_write), .req_mode(req_mode), .direct_offset(direct_offset), .high_low_pair(high_low_pair),
        .pointer_pair_two(pointer_pair_two), .pointer_pair_three(pointer_pair_three),
        .stack_pointer(stack_pointer), .stack_bank_select(stack_bank_select), .req_wdata(req_wdata),
        .periph_rdata(periph_rdata), .bank_enable_flag(bank_enable_flag), .bank_select_reg(bank_select_reg),
        .mem_addr(mem_addr), .ram_sel(ram_sel), .periph_sel(periph_sel), .periph_rd(periph_rd),
        .periph_wr(periph_wr), .periph_wdata(periph_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
    dmba_periph_model model (.clock(clock), .periph_rd(periph_rd), .periph_wr(periph_wr), .mem_addr(mem_addr),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One control pulse, then the flag and bank select are compared; the next call or access lowers it
    task automatic ctl(input logic s, c, en, r, bw, input logic [3:0] bd, input logic ef, input logic [3:0] eb);
        flag_set = s; flag_clr = c; ctx_enter = en; ctx_return = r; bank_sel_wr = bw; bank_sel_wdata = bd;
        @(posedge clock);
        #1;
        chk("bank_enable_flag", ef, bank_enable_flag);
        chk("bank_select_reg", eb, bank_select_reg);
    endtask
    // Wrong sources carry the inverted offset so a wrong pick shows
    task automatic acc(input dmba_pkg::dmba_mode_t m, input logic w, input logic [7:0] o, input logic [3:0] d,
                       input logic [11:0] ea, input logic [3:0] ed);
        {flag_set, flag_clr, ctx_enter, ctx_return, bank_sel_wr} = 5'h00;
        direct_offset = (m == dmba_pkg::DMBA_MODE_DIRECT) ? o : ~o;
        high_low_pair = (m == dmba_pkg::DMBA_MODE_HL) ? o : ~o;
        pointer_pair_two = (m == dmba_pkg::DMBA_MODE_PAIR_TWO) ? o : ~o;
        pointer_pair_three = (m == dmba_pkg::DMBA_MODE_PAIR_THREE) ? o : ~o;
        stack_pointer = (m == dmba_pkg::DMBA_MODE_STACK) ? o : ~o;
        req_mode = m; req_write = w; req_wdata = d; req_valid = 1;
        @(posedge clock);
        #1;
        req_valid = 0;
        chk("mem_addr", ea, mem_addr);
        chk("ram_sel", ea <= 12'h3FF, ram_sel);
        chk("periph_sel", ea >= 12'hF80, periph_sel);
        chk("periph_rd", !w && ea >= 12'hF80, periph_rd);
        chk("periph_wr", w && ea >= 12'hF80, periph_wr);
        @(posedge clock);
        #1;
        chk("rd_valid", !w, rd_valid);
        if (!w) chk("rd_data", ed, rd_data);
    endtask
    task automatic t_direct();
        acc(dmba_pkg::DMBA_MODE_DIRECT, 1, 8'h7F, 4'h9, 12'h07F, 4'h0);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 0, 8'h7F, 4'h0, 12'h07F, 4'h9);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 1, 8'h85, 4'hC, 12'hF85, 4'h0);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 0, 8'h85, 4'h0, 12'hF85, 4'hC);
        ctl(1, 0, 0, 0, 1, 4'h3, 1, 4'h3);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 1, 8'hFF, 4'h6, 12'h3FF, 4'h0);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 0, 8'hFF, 4'h0, 12'h3FF, 4'h6);
    endtask
    task automatic t_bank_sel();
        logic [3:0] legal [5] = '{4'h0, 4'h1, 4'h2, 4'hF, 4'h3};
        foreach (legal[i]) ctl(0, 0, 0, 0, 1, legal[i], 1, legal[i]);
        ctl(0, 0, 0, 0, 1, 4'h4, 1, 4'h3);
        ctl(0, 0, 0, 0, 1, 4'hE, 1, 4'h3);
    endtask
    task automatic t_pointers();
        acc(dmba_pkg::DMBA_MODE_HL, 1, 8'h21, 4'hA, 12'h321, 4'h0);
        acc(dmba_pkg::DMBA_MODE_PAIR_TWO, 1, 8'h21, 4'h5, 12'h021, 4'h0);
        acc(dmba_pkg::DMBA_MODE_PAIR_THREE, 0, 8'h21, 4'h0, 12'h021, 4'h5);
        ctl(0, 1, 0, 0, 0, 4'h0, 0, 4'h3);
        acc(dmba_pkg::DMBA_MODE_HL, 0, 8'h21, 4'h0, 12'h021, 4'h5);
        for (int s = 0; s < 4; s++) begin
            stack_bank_select = s[1:0];
            if (s == 1 || s == 2) acc(dmba_pkg::DMBA_MODE_STACK, 1, 8'h21, 4'h8 | 4'(s), {2'h0, s[1:0], 8'h21}, 4'h0);
            acc(dmba_pkg::DMBA_MODE_STACK, 0, 8'h21, 4'h0, {2'h0, s[1:0], 8'h21},
                s == 0 ? 4'h5 : (s == 3 ? 4'hA : 4'h8 | 4'(s)));
        end
    endtask
    task automatic t_hole();
        ctl(1, 0, 0, 0, 1, 4'hF, 1, 4'hF);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 1, 8'h10, 4'h7, 12'hF10, 4'h0);
        acc(dmba_pkg::DMBA_MODE_DIRECT, 0, 8'h10, 4'h0, 12'hF10, 4'h0);
        // An unused mode code must be dropped: no read comes back
        req_mode = dmba_pkg::dmba_mode_t'(3'h5); req_valid = 1;
        @(posedge clock);
        #1;
        req_valid = 0;
        @(posedge clock);
        #1;
        chk("rd_valid", 12'h000, rd_valid);
    endtask
    task automatic t_ctx();
        ctl(0, 0, 1, 0, 0, 4'h0, 1, 4'hF);
        ctl(0, 1, 0, 0, 0, 4'h0, 0, 4'hF);
        ctl(0, 0, 1, 0, 0, 4'h0, 0, 4'hF);
        ctl(1, 0, 0, 0, 0, 4'h0, 1, 4'hF);
        ctl(0, 0, 0, 1, 0, 4'h0, 0, 4'hF);
        ctl(0, 0, 0, 1, 0, 4'h0, 1, 4'hF);
        ctl(0, 1, 1, 0, 0, 4'h0, 0, 4'hF);
        ctl(0, 0, 0, 1, 0, 4'h0, 1, 4'hF);
    endtask
    initial begin
        #100us;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1;
        chk("bank_enable_flag", 12'h000, bank_enable_flag);
        chk("bank_select_reg", 12'h000, bank_select_reg);
        t_direct();
        t_bank_sel();
        t_pointers();
        t_hole();
        t_ctx();
        end_sim();
    end
endmodule

/* dv/dmba_periph_model.sv */
// Peripheral area model answering reads and taking writes from the block
module dmba_periph_model (
    input  wire logic        clock,
    input  wire logic        periph_rd,
    input  wire logic        periph_wr,
    input  wire logic [11:0] mem_addr,
    input  wire logic [3:0]  periph_wdata,
    output logic [3:0]       periph_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] store_reg [0:127];
    logic [3:0] last_reg = 4'h5;
    // Not read: pattern flips every cycle so a stale sample shows
    assign periph_rdata = periph_rd ? store_reg[mem_addr[6:0]] : ~last_reg;
    always @(posedge clock) begin
        last_reg <= periph_rdata;
        if (periph_wr) begin
            store_reg[mem_addr[6:0]] <= periph_wdata;
        end
    end
endmodule

/* verilog/dmba_dec_if.sv */
// Carrier between the address builder and the region decoder
`include "dmba_defs.svh"
interface dmba_dec_if;
    logic [`DMBA_ADDR_W-1:0] addr;
    logic                    ram_sel;
    logic                    per_sel;
    modport gen (output addr, input ram_sel, input per_sel);
    modport dec (input addr, output ram_sel, output per_sel);
endinterface

/* verilog/dmba_decode.sv */
// Region decoder: static RAM, peripheral area, or nothing
`include "dmba_defs.svh"
module dmba_decode (
    dmba_dec_if.dec dec
);
    // Addresses 400H..F7FH fall through with neither select
    assign dec.ram_sel = (dec.addr <= `DMBA_RAM_LAST);
    assign dec.per_sel = (dec.addr >= `DMBA_PER_FIRST);
endmodule

/* verilog/dmba_defs.svh */
// Address map, bank numbers and fixed values of the data memory bank addressing block
`ifndef DMBA_DEFS_SVH
`define DMBA_DEFS_SVH
`define DMBA_ADDR_W       12
`define DMBA_BANK_W       4
`define DMBA_OFS_W        8
`define DMBA_NIB_W        4
`define DMBA_SBS_W        2
`define DMBA_RAM_WORDS    1024
`define DMBA_RAM_AW       10
`define DMBA_RAM_FIRST    12'h000
`define DMBA_RAM_LAST     12'h3FF
`define DMBA_PER_FIRST    12'hF80
`define DMBA_PER_LAST     12'hFFF
`define DMBA_BANK_ZERO    4'h0
`define DMBA_BANK_ONE     4'h1
`define DMBA_BANK_TWO     4'h2
`define DMBA_BANK_THREE   4'h3
`define DMBA_BANK_PERIPH  4'hF
`define DMBA_OFS_MSB      7
`define DMBA_SBS_PAD      2'h0
`define DMBA_UNDEF_RDATA  4'h0
`define DMBA_SAVE_DEPTH   8
`define DMBA_SAVE_PW      3
`define DMBA_PTR_ONE      3'h1
`endif

/* verilog/dmba_pkg.sv */
// Types shared by the data memory bank addressing modules
package dmba_pkg;
    typedef enum logic [2:0] {
        DMBA_MODE_DIRECT,
        DMBA_MODE_HL,
        DMBA_MODE_PAIR_TWO,
        DMBA_MODE_PAIR_THREE,
        DMBA_MODE_STACK
    } dmba_mode_t;
endpackage

/* verilog/dmba_top.sv */
// Data memory bank addressing: bank logic, address build, RAM and peripheral steering
`include "dmba_defs.svh"
module dmba_top (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    flag_set,
    input  wire logic                    flag_clr,
    input  wire logic                    bank_sel_wr,
    input  wire logic [`DMBA_BANK_W-1:0] bank_sel_wdata,
    input  wire logic                    ctx_enter,
    input  wire logic                    ctx_return,
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire dmba_pkg::dmba_mode_t    req_mode,
    input  wire logic [`DMBA_OFS_W-1:0]  direct_offset,
    input  wire logic [`DMBA_OFS_W-1:0]  high_low_pair,
    input  wire logic [`DMBA_OFS_W-1:0]  pointer_pair_two,
    input  wire logic [`DMBA_OFS_W-1:0]  pointer_pair_three,
    input  wire logic [`DMBA_OFS_W-1:0]  stack_pointer,
    input  wire logic [`DMBA_SBS_W-1:0]  stack_bank_select,
    input  wire logic [`DMBA_NIB_W-1:0]  req_wdata,
    input  wire logic [`DMBA_NIB_W-1:0]  periph_rdata,
    output logic                         bank_enable_flag,
    output logic [`DMBA_BANK_W-1:0]      bank_select_reg,
    output logic [`DMBA_ADDR_W-1:0]      mem_addr,
    output logic                         ram_sel,
    output logic                         periph_sel,
    output logic                         periph_rd,
    output logic                         periph_wr,
    output logic [`DMBA_NIB_W-1:0]       periph_wdata,
    output logic                         rd_valid,
    output logic [`DMBA_NIB_W-1:0]       rd_data
);
    logic                       flag_reg;
    logic                       flag_next;
    logic [`DMBA_BANK_W-1:0]    bank_sel_reg;
    logic [`DMBA_BANK_W-1:0]    bank_sel_next;
    logic [`DMBA_SAVE_PW-1:0]   save_ptr_reg;
    logic [`DMBA_SAVE_PW-1:0]   save_ptr_pop;
    logic                       save_mem_reg [`DMBA_SAVE_DEPTH];
    logic [`DMBA_NIB_W-1:0]     ram_mem [`DMBA_RAM_WORDS];
    logic [`DMBA_ADDR_W-1:0]    addr_reg;
    logic                       ram_sel_reg;
    logic                       per_sel_reg;
    logic                       s1_valid_reg;
    logic                       s1_write_reg;
    logic [`DMBA_NIB_W-1:0]     wdata_reg;
    logic                       rd_valid_reg;
    logic [`DMBA_NIB_W-1:0]     rd_data_reg;
    logic [`DMBA_NIB_W-1:0]     rd_data_next;
    logic                       bank_sel_legal;
    logic                       is_direct;
    logic                       is_hl;
    logic                       is_pair;
    logic                       is_stack;
    logic [`DMBA_BANK_W-1:0]    bank_direct;
    logic [`DMBA_BANK_W-1:0]    bank_hl;
    logic [`DMBA_BANK_W-1:0]    bank_stack;
    logic [`DMBA_BANK_W-1:0]    active_bank;
    logic [`DMBA_OFS_W-1:0]     offset_sel;
    logic [`DMBA_RAM_AW-1:0]    ram_index;
    logic                       s1_rd;
    logic                       req_ok;
    logic                       periph_rd_reg;
    logic                       periph_wr_reg;
    logic [`DMBA_BANK_W-1:0]    addr_bank;

    dmba_dec_if dec_bus ();

    dmba_decode u_decode (
        .dec (dec_bus)
    );

    // Bank select write: illegal values leave the register unchanged
    assign bank_sel_legal = (bank_sel_wdata == `DMBA_BANK_ZERO) ||
                            (bank_sel_wdata == `DMBA_BANK_ONE) ||
                            (bank_sel_wdata == `DMBA_BANK_TWO) ||
                            (bank_sel_wdata == `DMBA_BANK_THREE) ||
                            (bank_sel_wdata == `DMBA_BANK_PERIPH);
    assign bank_sel_next  = (bank_sel_wr && bank_sel_legal) ? bank_sel_wdata : bank_sel_reg;

    // Return restores the saved flag and wins over set or clear in the same cycle
    assign save_ptr_pop = save_ptr_reg - `DMBA_PTR_ONE;
    assign flag_next = ctx_return ? save_mem_reg[save_ptr_pop] :
                       flag_set   ? 1'b1 :
                       flag_clr   ? 1'b0 : flag_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_reg     <= 1'b0;
            bank_sel_reg <= `DMBA_BANK_ZERO;
        end else begin
            flag_reg     <= flag_next;
            bank_sel_reg <= bank_sel_next;
        end
    end

    // Save stack of flag values; nesting deeper than the depth wraps and loses the oldest
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            save_ptr_reg <= '0;
        end else if (ctx_enter && !ctx_return) begin
            save_ptr_reg <= save_ptr_reg + `DMBA_PTR_ONE;
        end else if (ctx_return && !ctx_enter) begin
            save_ptr_reg <= save_ptr_pop;
        end
    end

    generate
        for (genvar i = 0; i < `DMBA_SAVE_DEPTH; i++) begin : g_save
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    save_mem_reg[i] <= 1'b0;
                end else if (ctx_enter && !ctx_return && (int'(save_ptr_reg) == i)) begin
                    save_mem_reg[i] <= flag_reg;
                end
            end
        end
    endgenerate

    // Bank choice per addressing mode
    assign is_direct   = (req_mode == dmba_pkg::DMBA_MODE_DIRECT);
    assign is_hl       = (req_mode == dmba_pkg::DMBA_MODE_HL);
    assign is_pair     = (req_mode == dmba_pkg::DMBA_MODE_PAIR_TWO) ||
                         (req_mode == dmba_pkg::DMBA_MODE_PAIR_THREE);
    assign is_stack    = (req_mode == dmba_pkg::DMBA_MODE_STACK);
    assign bank_direct = flag_reg ? bank_sel_reg :
                         (direct_offset[`DMBA_OFS_MSB] ? `DMBA_BANK_PERIPH : `DMBA_BANK_ZERO);
    assign bank_hl     = {`DMBA_BANK_W{flag_reg}} & bank_sel_reg;
    assign bank_stack  = {`DMBA_SBS_PAD, stack_bank_select};
    assign active_bank = is_direct ? bank_direct :
                         is_hl     ? bank_hl :
                         is_stack  ? bank_stack : `DMBA_BANK_ZERO;
    assign offset_sel  = is_direct ? direct_offset :
                         is_hl     ? high_low_pair :
                         is_stack  ? stack_pointer :
                         (req_mode == dmba_pkg::DMBA_MODE_PAIR_THREE) ? pointer_pair_three : pointer_pair_two;
    assign dec_bus.addr = {active_bank, offset_sel};

    // Stage 1: address and selects registered; an illegal mode code is dropped
    assign req_ok = req_valid && (is_direct || is_hl || is_pair || is_stack);

    // Strobes come off their own flops so the pins never glitch on decode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_valid_reg  <= 1'b0;
            s1_write_reg  <= 1'b0;
            addr_reg      <= `DMBA_RAM_FIRST;
            ram_sel_reg   <= 1'b0;
            per_sel_reg   <= 1'b0;
            wdata_reg     <= '0;
            periph_rd_reg <= 1'b0;
            periph_wr_reg <= 1'b0;
        end else begin
            s1_valid_reg  <= req_ok;
            periph_rd_reg <= req_ok && !req_write && dec_bus.per_sel;
            periph_wr_reg <= req_ok && req_write && dec_bus.per_sel;
            s1_write_reg <= req_write;
            addr_reg     <= dec_bus.addr;
            ram_sel_reg  <= dec_bus.ram_sel;
            per_sel_reg  <= dec_bus.per_sel;
            wdata_reg    <= req_wdata;
        end
    end

    // Stage 2: RAM write or read; writes to the hole reach nothing
    assign ram_index    = addr_reg[`DMBA_RAM_AW-1:0];
    assign s1_rd        = s1_valid_reg && !s1_write_reg;
    assign rd_data_next = ram_sel_reg ? ram_mem[ram_index] :
                          per_sel_reg ? periph_rdata : `DMBA_UNDEF_RDATA;

    always_ff @(posedge clock) begin
        if (s1_valid_reg && s1_write_reg && ram_sel_reg) begin
            ram_mem[ram_index] <= wdata_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= '0;
        end else begin
            rd_valid_reg <= s1_rd;
            rd_data_reg  <= s1_rd ? rd_data_next : rd_data_reg;
        end
    end

    assign bank_enable_flag = flag_reg;
    assign bank_select_reg  = bank_sel_reg;
    assign mem_addr         = addr_reg;
    assign ram_sel          = ram_sel_reg;
    assign periph_sel       = per_sel_reg;
    assign periph_rd        = periph_rd_reg;
    assign periph_wr        = periph_wr_reg;
    assign addr_bank        = addr_reg[`DMBA_ADDR_W-1:`DMBA_OFS_W];
    assign periph_wdata     = wdata_reg;
    assign rd_valid         = rd_valid_reg;
    assign rd_data          = rd_data_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ram_range_a: assert property (ram_sel_reg |-> addr_reg <= `DMBA_RAM_LAST)
        else $error("RAM selected outside its range");
    periph_range_a: assert property (addr_reg >= `DMBA_PER_FIRST |-> per_sel_reg && !ram_sel_reg)
        else $error("Peripheral area not selected");
    addr_offset_a: assert property (req_valid && is_hl |=> addr_reg[`DMBA_OFS_W-1:0] == $past(high_low_pair))
        else $error("Low byte not taken from the pointer");
    bank_legal_a: assert property (bank_sel_wr && !bank_sel_legal |=> $stable(bank_sel_reg))
        else $error("Illegal bank select value accepted");
    bank_enabled_a: assert property (is_direct && flag_reg |=> addr_bank == $past(bank_sel_reg))
        else $error("Enabled direct bank differs from select");
    flag_restore_a: assert property (ctx_enter && !ctx_return ##1 ctx_return && !ctx_enter
        |=> flag_reg == $past(flag_reg, 2))
        else $error("Bank enable flag not restored on return");
    direct_split_a: assert property (is_direct && !flag_reg && direct_offset[`DMBA_OFS_MSB]
        |=> addr_bank == `DMBA_BANK_PERIPH)
        else $error("Upper direct half not in bank 15");
    hl_and_a: assert property (is_hl && !flag_reg |=> addr_bank == `DMBA_BANK_ZERO)
        else $error("High-low access with cleared flag left bank 0");
    pair_zero_a: assert property (is_pair |=> addr_bank == `DMBA_BANK_ZERO)
        else $error("Pointer pair access left bank 0");
    stack_bank_a: assert property (is_stack
        |=> addr_reg == {`DMBA_SBS_PAD, $past(stack_bank_select), $past(stack_pointer)})
        else $error("Stack address wrong");
    hole_read_a: assert property (s1_rd && !ram_sel_reg && !per_sel_reg
        |=> rd_valid_reg && rd_data_reg == `DMBA_UNDEF_RDATA)
        else $error("Hole read did not give the fixed value");
    periph_strobe_a: assert property (periph_rd_reg || periph_wr_reg |-> per_sel_reg && s1_valid_reg)
        else $error("Peripheral strobe without a peripheral access");
endmodule
